// [jpf_pkg.sv]
// constants and types shared by the jtag fanout block
package jpf_pkg;

  localparam int unsigned NUM_LSP = 7;           // local scan ports, port 0 on a backplane set
  localparam int unsigned NUM_EXT_LSP = 6;       // local ports 1..6 on their own pins
  localparam int unsigned NUM_SETS = 2;          // interchangeable backplane pin sets
  localparam int unsigned SLOT_W = 8;            // slot identification inputs
  localparam int unsigned NUM_NOTIFY = 3;        // dedicated notify pins, ports 1..3
  localparam int unsigned SYNC_STAGES = 3;       // flops on every asynchronous pin

  localparam logic MPS_SET0 = 1'b0;              // select value making set 0 the master
  localparam logic [6:0] SEL_PORT0 = 7'h01;      // only port 0 selected
  localparam logic [6:0] SEL_PORT1 = 7'h02;      // only port 1 selected

  localparam logic [6:0] SEL_RESET = 7'h00;      // no local port selected after reset
  localparam logic [7:0] SLOT_RESET = 8'h00;     // slot address before first sample
  localparam logic OE_N_RESET = 1'b1;            // local outputs released after reset
  localparam logic PT_RESET = 1'b1;              // pass-through pins idle high (pull-ups)
  localparam logic TMS_PARK = 1'b1;              // tms seen by unselected chains
  localparam logic BYP_CAPTURE = 1'b0;           // bypass bit loads zero in capture
  localparam logic [7:0] IR_RESET = 8'h00;       // instruction shifter reset value

  // ieee 1149.1 tap controller states
  typedef enum logic [3:0] {
    TAP_RESET,
    TAP_IDLE,
    TAP_SEL_DR,
    TAP_CAP_DR,
    TAP_SH_DR,
    TAP_EX1_DR,
    TAP_PA_DR,
    TAP_EX2_DR,
    TAP_UPD_DR,
    TAP_SEL_IR,
    TAP_CAP_IR,
    TAP_SH_IR,
    TAP_EX1_IR,
    TAP_PA_IR,
    TAP_EX2_IR,
    TAP_UPD_IR
  } jpf_tap_e;

endpackage : jpf_pkg

// [jpf_sync3.sv]
// three-flop pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none

module jpf_sync3 #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] s1_q;   // metastable stage, read only by s2
  logic [WIDTH-1:0] s2_q;   // second stage
  logic [WIDTH-1:0] s3_q;   // third stage
  logic [WIDTH-1:0] out_q;  // filtered level
  logic [WIDTH-1:0] out_d;

  // a bit changes only once stages two and three agree
  always_comb begin
    out_d = (s3_q & ~(s2_q ^ s3_q)) | (out_q & (s2_q ^ s3_q));
  end

  // register stages
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      out_q <= RST_VAL;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign sync_o = out_q;

endmodule : jpf_sync3

`default_nettype wire

// [jpf_tap.sv]
// tap controller state machine sequenced by the master tms
`timescale 1ns/10ps
`default_nettype none

module jpf_tap (
  input wire logic tck_i,
  input wire logic rst_n_i,
  input wire logic tms_i,
  output logic capture_dr_o,
  output logic shift_dr_o,
  output logic capture_ir_o,
  output logic shift_ir_o
);
  import jpf_pkg::*;

  jpf_tap_e state_q;  // current tap state
  jpf_tap_e state_d;

  // standard sixteen-state walk
  always_comb begin
    unique case (state_q)
      TAP_RESET:  state_d = tms_i ? TAP_RESET : TAP_IDLE;
      TAP_IDLE:   state_d = tms_i ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: state_d = tms_i ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: state_d = tms_i ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  state_d = tms_i ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: state_d = tms_i ? TAP_UPD_DR : TAP_PA_DR;
      TAP_PA_DR:  state_d = tms_i ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: state_d = tms_i ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: state_d = tms_i ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: state_d = tms_i ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: state_d = tms_i ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  state_d = tms_i ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: state_d = tms_i ? TAP_UPD_IR : TAP_PA_IR;
      TAP_PA_IR:  state_d = tms_i ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: state_d = tms_i ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: state_d = tms_i ? TAP_SEL_DR : TAP_IDLE;
    endcase
  end

  // test reset forces test-logic-reset without a clock
  always_ff @(posedge tck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= TAP_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign capture_dr_o = (state_q == TAP_CAP_DR);
  assign shift_dr_o = (state_q == TAP_SH_DR);
  assign capture_ir_o = (state_q == TAP_CAP_IR);
  assign shift_ir_o = (state_q == TAP_SH_IR);

endmodule : jpf_tap

`default_nettype wire

// [jpf_fanout.sv]
// jtag backplane to seven local scan port fanout with pass-through bits
//
// Overview of operation
// [R01] backplane tdo returns own and local chain data
// [R02] master samples tdo to see addressed response
// [R03] backplane tck clocks all scan operations
// [R04] backplane trst low resets logic asynchronously
// [R05] notify output high exactly while tdo released
// [R06] select pin picks master set, other is port0
// [R07] backplane pass-through input feeds single selected port
// [R08] backplane pass-through output reflects single selected port
// [R09] slot inputs give the device's eight-bit address
// [R10] local enable high releases all local outputs
// [R11] local tck is a buffered backplane tck
// [R12] local trst is gated backplane trst
// [R13] local pass-through inputs only on ports 0,1
// [R14] local pass-through outputs follow backplane, single selection
// [R15] each local port has its own pins
// [R16] select low makes set 0 master
// [R17] backplane tms steps own and local taps
// [R18] pass-through outputs released unless exactly one selected
`timescale 1ns/10ps
`default_nettype none

module jpf_fanout (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic master_port_select_i,
  input wire logic [jpf_pkg::SLOT_W-1:0] slot_id_i,
  input wire logic [jpf_pkg::NUM_LSP-1:0] lsp_select_i,
  input wire logic local_oe_n_i,
  input wire logic [jpf_pkg::NUM_SETS-1:0] b_tck_i,
  output logic [jpf_pkg::NUM_SETS-1:0] b_tck_o,
  output logic [jpf_pkg::NUM_SETS-1:0] b_tck_oe_o,
  input wire logic [jpf_pkg::NUM_SETS-1:0] b_tms_i,
  output logic [jpf_pkg::NUM_SETS-1:0] b_tms_o,
  output logic [jpf_pkg::NUM_SETS-1:0] b_tms_oe_o,
  input wire logic [jpf_pkg::NUM_SETS-1:0] b_trst_n_i,
  output logic [jpf_pkg::NUM_SETS-1:0] b_trst_n_o,
  output logic [jpf_pkg::NUM_SETS-1:0] b_trst_n_oe_o,
  input wire logic [jpf_pkg::NUM_SETS-1:0] b_tdi_i,
  input wire logic [jpf_pkg::NUM_SETS-1:0] b_tdo_i,
  output logic [jpf_pkg::NUM_SETS-1:0] b_tdo_o,
  output logic [jpf_pkg::NUM_SETS-1:0] b_tdo_oe_o,
  output logic [jpf_pkg::NUM_SETS-1:0] b_tristate_notify_o,
  input wire logic [jpf_pkg::NUM_SETS-1:0] b_passthru_in_zero_i,
  input wire logic [jpf_pkg::NUM_SETS-1:0] b_passthru_in_one_i,
  output logic [jpf_pkg::NUM_SETS-1:0] b_passthru_out_zero_o,
  output logic [jpf_pkg::NUM_SETS-1:0] b_passthru_out_one_o,
  output logic [jpf_pkg::NUM_SETS-1:0] b_passthru_oe_o,
  input wire logic [jpf_pkg::NUM_EXT_LSP-1:0] lsp_tdi_i,
  output logic [jpf_pkg::NUM_EXT_LSP-1:0] lsp_tdo_o,
  output logic [jpf_pkg::NUM_EXT_LSP-1:0] lsp_tdo_oe_o,
  output logic [jpf_pkg::NUM_EXT_LSP-1:0] lsp_tms_o,
  output logic [jpf_pkg::NUM_EXT_LSP-1:0] lsp_tms_oe_o,
  output logic [jpf_pkg::NUM_EXT_LSP-1:0] lsp_tck_o,
  output logic [jpf_pkg::NUM_EXT_LSP-1:0] lsp_tck_oe_o,
  output logic [jpf_pkg::NUM_EXT_LSP-1:0] lsp_trst_n_o,
  output logic [jpf_pkg::NUM_EXT_LSP-1:0] lsp_trst_n_oe_o,
  output logic [jpf_pkg::NUM_NOTIFY-1:0] lsp_tristate_notify_o,
  input wire logic lsp1_passthru_in_zero_i,
  input wire logic lsp1_passthru_in_one_i,
  output logic lsp1_passthru_out_zero_o,
  output logic lsp1_passthru_out_one_o,
  output logic lsp1_passthru_oe_o
);
  import jpf_pkg::*;

  // system clock side: select, enables, pass-through
  logic ms_c;                      // synced master select, clk_i domain
  logic [NUM_LSP-1:0] sel_c;       // synced local selection, clk_i domain
  logic oe_n_c;                    // synced local output enable
  logic [1:0] bpa_c [NUM_SETS];    // synced backplane pass-through inputs
  logic [1:0] la1_c;               // synced port 1 pass-through inputs
  logic master_tck;                // tck of the active set
  logic master_trst_n;             // trst of the active set
  logic tck_rst_n;                 // async reset of the scan domain

  jpf_sync3 #(.WIDTH(1), .RST_VAL(MPS_SET0)) u_ms_c (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .async_i(master_port_select_i),
    .sync_o(ms_c)
  );
  jpf_sync3 #(.WIDTH(NUM_LSP), .RST_VAL(SEL_RESET)) u_sel_c (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .async_i(lsp_select_i),
    .sync_o(sel_c)
  );
  jpf_sync3 #(.WIDTH(1), .RST_VAL(OE_N_RESET)) u_oe_c (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .async_i(local_oe_n_i),
    .sync_o(oe_n_c)
  );

  // pass-through pins are plain levels, filtered like any other pin
  for (genvar s = 0; s < NUM_SETS; s++) begin : g_bpa
    jpf_sync3 #(.WIDTH(2), .RST_VAL({PT_RESET, PT_RESET})) u_bpa (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .async_i({b_passthru_in_one_i[s], b_passthru_in_zero_i[s]}),
      .sync_o(bpa_c[s])
    );
  end
  jpf_sync3 #(.WIDTH(2), .RST_VAL({PT_RESET, PT_RESET})) u_la1 (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .async_i({lsp1_passthru_in_one_i, lsp1_passthru_in_zero_i}),
    .sync_o(la1_c)
  );

  // clock and reset follow the active set; select is a strap, so no glitch-free mux
  assign master_tck = (ms_c == MPS_SET0) ? b_tck_i[0] : b_tck_i[1]; // [R06] [R16] [R03]
  assign master_trst_n = (ms_c == MPS_SET0) ? b_trst_n_i[0] : b_trst_n_i[1]; // [R16]
  assign tck_rst_n = resetn_i & master_trst_n; // [R04]

  logic loc_en_q, loc_en_d;                      // local pins driven
  logic [NUM_LSP-1:0] ltdo_en_q, ltdo_en_d;      // local tdo driven, per port
  logic [NUM_NOTIFY:0] lnt_q, lnt_d;             // notify for ports 0..3
  logic [1:0] trst_gate_q;                       // local reset release stretcher
  logic single0, single1;                        // exactly port 0 / port 1 selected
  logic [1:0] bpa_master, bpa_port0;             // pass-through inputs by role
  logic [1:0] bpy_q [NUM_SETS], bpy_d [NUM_SETS]; // pass-through outputs per set
  logic [NUM_SETS-1:0] bpy_oe_q, bpy_oe_d;
  logic [1:0] ly1_q, ly1_d;
  logic ly1_oe_q, ly1_oe_d;

  // enables and notify come from the same computation so they never disagree
  always_comb begin
    loc_en_d = ~oe_n_c; // [R10]
    ltdo_en_d = sel_c & {NUM_LSP{~oe_n_c}}; // [R10] [R15]
    lnt_d = ~ltdo_en_d[NUM_NOTIFY:0]; // [R05]
  end

  // pass-through routing; only ports 0 and 1 own these pins
  always_comb begin
    single0 = (sel_c == SEL_PORT0); // [R18]
    single1 = (sel_c == SEL_PORT1); // [R18]
    bpa_master = (ms_c == MPS_SET0) ? bpa_c[0] : bpa_c[1];
    bpa_port0 = (ms_c == MPS_SET0) ? bpa_c[1] : bpa_c[0];
    for (int s = 0; s < NUM_SETS; s++) begin
      if (s == int'(ms_c)) begin
        // master side shows the single selected port's input
        bpy_d[s] = single0 ? bpa_port0 : la1_c; // [R08] [R13]
        bpy_oe_d[s] = single0 | single1; // [R08] [R18]
      end else begin
        // port 0 side follows the master input
        bpy_d[s] = bpa_master; // [R07] [R14]
        bpy_oe_d[s] = single0 & ~oe_n_c; // [R07] [R10] [R18]
      end
    end
    ly1_d = bpa_master; // [R07] [R14]
    ly1_oe_d = single1 & ~oe_n_c; // [R14] [R10] [R18]
  end

  // system clock registers
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      loc_en_q <= 1'b0;
      ltdo_en_q <= '0;
      lnt_q <= '1;
      bpy_q <= '{default: {PT_RESET, PT_RESET}}; // idle level of the pull-ups
      bpy_oe_q <= '0;
      ly1_q <= {PT_RESET, PT_RESET};
      ly1_oe_q <= 1'b0;
    end else begin
      loc_en_q <= loc_en_d;
      ltdo_en_q <= ltdo_en_d;
      lnt_q <= lnt_d;
      bpy_q <= bpy_d;
      bpy_oe_q <= bpy_oe_d;
      ly1_q <= ly1_d;
      ly1_oe_q <= ly1_oe_d;
    end
  end

  // local trst drops at once with the master trst, rises two clk edges later
  always_ff @(posedge clk_i or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      trst_gate_q <= 2'b00;
    end else begin
      trst_gate_q <= {trst_gate_q[0], 1'b1}; // [R12]
    end
  end

  // scan side: runs on the active backplane tck
  logic ms_t;                      // master select seen by the scan side
  logic [NUM_LSP-1:0] sel_t;       // local selection seen by the scan side
  logic [SLOT_W-1:0] slot_t;       // synced slot address
  logic master_tdi, master_tms;
  logic cap_dr, sh_dr, cap_ir, sh_ir;
  logic [NUM_LSP-1:0] chain_tdi;   // data returned by each local chain
  logic [NUM_LSP:0] stage;         // serial path through selected chains
  logic [SLOT_W-1:0] ir_q, ir_d;   // own instruction shifter
  logic byp_q, byp_d;              // own bypass bit
  logic [NUM_LSP-1:0] ltdo_q, ltdo_d;
  logic mtdo_q, mtdo_d;
  logic mtdo_en_q, mtdo_en_d;
  logic mnt_q, mnt_d;

  jpf_sync3 #(.WIDTH(1), .RST_VAL(MPS_SET0)) u_ms_t (
    .clk_i(master_tck),
    .resetn_i(tck_rst_n),
    .async_i(master_port_select_i),
    .sync_o(ms_t)
  );
  jpf_sync3 #(.WIDTH(NUM_LSP), .RST_VAL(SEL_RESET)) u_sel_t (
    .clk_i(master_tck),
    .resetn_i(tck_rst_n),
    .async_i(lsp_select_i),
    .sync_o(sel_t)
  );
  jpf_sync3 #(.WIDTH(SLOT_W), .RST_VAL(SLOT_RESET)) u_slot_t (
    .clk_i(master_tck),
    .resetn_i(tck_rst_n),
    .async_i(slot_id_i),
    .sync_o(slot_t) // [R09]
  );
  assign master_tdi = (ms_t == MPS_SET0) ? b_tdi_i[0] : b_tdi_i[1]; // [R06]
  assign master_tms = (ms_t == MPS_SET0) ? b_tms_i[0] : b_tms_i[1]; // [R06]
  // port 0 returns data on the tdi pin of the non-master set
  assign chain_tdi = {lsp_tdi_i, (ms_t == MPS_SET0) ? b_tdi_i[1] : b_tdi_i[0]}; // [R15]
  jpf_tap u_tap (
    .tck_i(master_tck),
    .rst_n_i(tck_rst_n),
    .tms_i(master_tms), // [R17]
    .capture_dr_o(cap_dr),
    .shift_dr_o(sh_dr),
    .capture_ir_o(cap_ir),
    .shift_ir_o(sh_ir)
  );

  // own path: the ir capture loads the slot address so an interrogating master reads it
  always_comb begin
    ir_d = ir_q;
    byp_d = byp_q;
    if (cap_ir) begin
      ir_d = slot_t; // [R09] [R02]
    end else if (sh_ir) begin
      ir_d = {master_tdi, ir_q[SLOT_W-1:1]};
    end
    if (cap_dr) begin
      byp_d = BYP_CAPTURE;
    end else if (sh_dr) begin
      byp_d = master_tdi;
    end
  end

  // serial stitching: own bit first, then each selected chain in port order
  always_comb begin
    stage[0] = sh_ir ? ir_q[0] : byp_q; // [R01]
    for (int k = 0; k < NUM_LSP; k++) begin
      stage[k+1] = sel_t[k] ? chain_tdi[k] : stage[k]; // [R01]
    end
    ltdo_d = stage[NUM_LSP-1:0];
    mtdo_d = stage[NUM_LSP]; // [R01]
    mtdo_en_d = sh_dr | sh_ir;
    mnt_d = ~(sh_dr | sh_ir); // [R05]
  end

  // capture and shift on the rising edge
  always_ff @(posedge master_tck or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      ir_q <= IR_RESET;
      byp_q <= BYP_CAPTURE;
    end else begin
      ir_q <= ir_d; // [R03]
      byp_q <= byp_d; // [R03]
    end
  end

  // test data out changes on the falling edge, as the chains expect
  always_ff @(negedge master_tck or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      ltdo_q <= '0;
      mtdo_q <= 1'b0;
      mtdo_en_q <= 1'b0;
      mnt_q <= 1'b1;
    end else begin
      ltdo_q <= ltdo_d;
      mtdo_q <= mtdo_d;
      mtdo_en_q <= mtdo_en_d;
      mnt_q <= mnt_d;
    end
  end

  // pin drivers
  // each set is either the master or local port 0, chosen by the strap
  always_comb begin
    for (int s = 0; s < NUM_SETS; s++) begin
      if (s == int'(ms_c)) begin
        b_tck_o[s] = 1'b0;
        b_tck_oe_o[s] = 1'b0;
        b_tms_o[s] = 1'b0;
        b_tms_oe_o[s] = 1'b0;
        b_trst_n_o[s] = 1'b0;
        b_trst_n_oe_o[s] = 1'b0;
        b_tdo_o[s] = mtdo_q; // [R01]
        b_tdo_oe_o[s] = mtdo_en_q;
        b_tristate_notify_o[s] = mnt_q; // [R05]
      end else begin
        b_tck_o[s] = master_tck; // [R11]
        b_tck_oe_o[s] = loc_en_q; // [R10]
        b_tms_o[s] = sel_t[0] ? master_tms : TMS_PARK; // [R17]
        b_tms_oe_o[s] = loc_en_q; // [R10]
        b_trst_n_o[s] = trst_gate_q[1]; // [R12]
        b_trst_n_oe_o[s] = loc_en_q; // [R10]
        b_tdo_o[s] = ltdo_q[0];
        b_tdo_oe_o[s] = ltdo_en_q[0]; // [R10]
        b_tristate_notify_o[s] = lnt_q[0]; // [R05]
      end
      b_passthru_out_zero_o[s] = bpy_q[s][0];
      b_passthru_out_one_o[s] = bpy_q[s][1];
      b_passthru_oe_o[s] = bpy_oe_q[s];
    end
  end

  // ports 1..6 each have their own tdi, tdo, tms, tck and trst pins; notify pins only on ports 1..3
  always_comb begin
    for (int k = 0; k < NUM_EXT_LSP; k++) begin
      lsp_tdo_o[k] = ltdo_q[k+1]; // [R15]
      lsp_tdo_oe_o[k] = ltdo_en_q[k+1]; // [R10]
      lsp_tms_o[k] = sel_t[k+1] ? master_tms : TMS_PARK; // [R17]
      lsp_tms_oe_o[k] = loc_en_q; // [R10]
      lsp_tck_o[k] = master_tck; // [R11]
      lsp_tck_oe_o[k] = loc_en_q; // [R10]
      lsp_trst_n_o[k] = trst_gate_q[1]; // [R12]
      lsp_trst_n_oe_o[k] = loc_en_q; // [R10]
    end
    lsp_tristate_notify_o = lnt_q[NUM_NOTIFY:1]; // [R05]
    lsp1_passthru_out_zero_o = ly1_q[0];
    lsp1_passthru_out_one_o = ly1_q[1];
    lsp1_passthru_oe_o = ly1_oe_q;
  end

  // the tdo pins are outputs of this block in both roles; their input side is unused
  wire logic unused_tdo = ^b_tdo_i;

endmodule : jpf_fanout

`default_nettype wire

// [jpf_fanout_assertions.sv]
// port checker for the jtag fanout block
`timescale 1ns/10ps
`default_nettype none

module jpf_fanout_assertions
  import jpf_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic master_port_select_i,
  input wire logic [6:0] lsp_select_i,
  input wire logic local_oe_n_i,
  input wire logic [1:0] b_tck_i,
  input wire logic [1:0] b_trst_n_i,
  input wire logic [1:0] b_tdo_oe_o,
  input wire logic [1:0] b_tristate_notify_o,
  input wire logic [1:0] b_passthru_in_zero_i,
  input wire logic [1:0] b_passthru_out_zero_o,
  input wire logic [1:0] b_passthru_oe_o,
  input wire logic [5:0] lsp_tdo_oe_o,
  input wire logic [5:0] lsp_tck_o,
  input wire logic [5:0] lsp_tck_oe_o,
  input wire logic [5:0] lsp_trst_n_o,
  input wire logic [2:0] lsp_tristate_notify_o,
  input wire logic lsp1_passthru_in_zero_i,
  input wire logic lsp1_passthru_out_zero_o,
  input wire logic lsp1_passthru_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  // pins held quiet long enough for the 4-5 edge filter to settle
  sequence quiet_s;
    (!local_oe_n_i && !master_port_select_i && $stable(lsp_select_i)
      && $stable(b_passthru_in_zero_i) && $stable(lsp1_passthru_in_zero_i))[*8];
  endsequence

  AST_NOTIFY_B: assert property (b_tristate_notify_o == ~b_tdo_oe_o)
    else $error("backplane notify disagrees with tdo enable");
  AST_NOTIFY_L: assert property (lsp_tristate_notify_o == ~lsp_tdo_oe_o[2:0])
    else $error("local notify disagrees with tdo enable");
  AST_LOCAL_TCK: assert property (lsp_tck_o == {6{b_tck_i[master_port_select_i]}})
    else $error("local tck is not the master tck");
  AST_OE_RELEASE: assert property (local_oe_n_i [*8] |->
    lsp_tck_oe_o == 6'h00 && lsp_tdo_oe_o == 6'h00 && !lsp1_passthru_oe_o)
    else $error("local outputs driven while released");
  AST_TRST_GATE: assert property (!b_trst_n_i[master_port_select_i] |->
    ##1 lsp_trst_n_o == 6'h00) else $error("local trst not low");
  AST_PT_REFUSE: assert property (($countones(lsp_select_i) != 1) [*8] |->
    b_passthru_oe_o == 2'b00 && !lsp1_passthru_oe_o) else $error("pass-through driven");
  AST_PT_FWD: assert property (quiet_s ##0 lsp_select_i == SEL_PORT0 |->
    b_passthru_out_zero_o[1] == b_passthru_in_zero_i[0] && b_passthru_oe_o == 2'b11)
    else $error("backplane pass-through not forwarded");
  AST_PT_BACK: assert property (quiet_s ##0 lsp_select_i == SEL_PORT0 |->
    b_passthru_out_zero_o[0] == b_passthru_in_zero_i[1]) else $error("port0 not returned");
  AST_PT_LSP1: assert property (quiet_s ##0 lsp_select_i == SEL_PORT1 |->
    lsp1_passthru_out_zero_o == b_passthru_in_zero_i[0]
    && b_passthru_out_zero_o[0] == lsp1_passthru_in_zero_i) else $error("port1 pass-through");

  // main scenarios reached
  COV_SHIFT: cover property (b_tdo_oe_o[0] ##1 !b_tdo_oe_o[0]);
  COV_PT: cover property (b_passthru_oe_o == 2'b11);
  COV_TRST: cover property (lsp_trst_n_o == 6'h00 ##1 lsp_trst_n_o == 6'h3f);
endmodule : jpf_fanout_assertions

bind jpf_fanout jpf_fanout_assertions jpf_fanout_assertions_inst (
  .clk_i, .resetn_i, .master_port_select_i, .lsp_select_i, .local_oe_n_i,
  .b_tck_i, .b_trst_n_i, .b_tdo_oe_o, .b_tristate_notify_o, .b_passthru_in_zero_i,
  .b_passthru_out_zero_o, .b_passthru_oe_o, .lsp_tdo_oe_o, .lsp_tck_o, .lsp_tck_oe_o,
  .lsp_trst_n_o, .lsp_tristate_notify_o, .lsp1_passthru_in_zero_i,
  .lsp1_passthru_out_zero_o, .lsp1_passthru_oe_o
);

`default_nettype wire

// [jpf_scan_master.sv]
// scan master model on the backplane tap pins
`timescale 1ns/10ps
`default_nettype none

module jpf_scan_master (
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  output logic trst_n_o,
  input wire logic tdo_i
);
  // tck stands still low between frames, other pins at pull-up level
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
    trst_n_o = 1'b1;
  end

  // one 6 ns tck period; pins change after the falling edge
  task automatic pulse(input logic t, input logic di, output logic dq);
    tms_o = t;
    tdi_o = di;
    #3;
    tck_o = 1'b1;
    dq = tdo_i;
    #3;
    tck_o = 1'b0;
  endtask : pulse

  // tms high walks any tap to test-logic-reset
  task automatic idle(input int n);
    logic d;
    repeat (n) pulse(1'b1, 1'b1, d);
  endtask : idle

  // full instruction scan from reset, lsb first
  task automatic ir_scan(input logic [7:0] din, output logic [7:0] dout);
    logic d;
    pulse(1'b0, 1'b1, d); // run idle
    pulse(1'b1, 1'b1, d); // select dr
    pulse(1'b1, 1'b1, d); // select ir
    pulse(1'b0, 1'b1, d); // capture ir
    pulse(1'b0, 1'b1, d); // shift ir
    for (int i = 0; i < 8; i++) begin
      pulse(i == 7, din[i], d);
      dout[i] = d;
    end
    pulse(1'b1, 1'b1, d); // update ir
    pulse(1'b0, 1'b1, d); // back to idle
  endtask : ir_scan

  // test reset level, async so no tck is needed
  task automatic set_trst(input logic v);
    trst_n_o <= v;
  endtask : set_trst
endmodule : jpf_scan_master

`default_nettype wire

// [jpf_fanout_tb_top.sv]
// self-checking testbench for the jtag fanout block
`timescale 1ns/10ps
`default_nettype none

module jpf_fanout_tb_top;
  import jpf_pkg::*;
  logic clk_i = 1'b0; // 200 MHz system clock
  logic rst_n = 1'b1; // async reset, active low, dropped at time zero
  logic ms = 1'b0; // master set strap
  logic oe_n = 1'b1; // local enable, active low
  logic [7:0] slot = 8'ha5; // slot address
  logic [6:0] sel = 7'h00; // local port selection
  logic [1:0] pa0 = 2'b11; // backplane pass-through zero ins
  logic [1:0] pa1 = 2'b11; // backplane pass-through one ins
  logic la0 = 1'b1; // port1 pass-through zero in
  logic la1 = 1'b1; // port1 pass-through one in
  wire m_tck, m_tms, m_tdi, m_trst_n; // scan master pins
  logic [1:0] tdo, tdo_oe, ntf, pt0, pt1, pt_oe, tck_oe;
  logic [5:0] ltdo, ltdo_oe, ltms_oe, ltck_oe, ltrst;
  logic [2:0] lntf;
  logic lp0, lp1, lp_oe;
  int err_count = 0;
  int num_checks = 0;
  // released tdo reads as its inverse
  wire m_tdo = tdo_oe[ms] ? tdo[ms] : ~tdo[ms];

  always #2.5 clk_i = ~clk_i;
  jpf_scan_master sm (.tck_o(m_tck), .tms_o(m_tms), .tdi_o(m_tdi),
    .trst_n_o(m_trst_n), .tdo_i(m_tdo));

  // tck fed to both sets so the strap mux never sees a dead pin
  jpf_fanout jpf_fanout_inst (.clk_i(clk_i), .resetn_i(rst_n),
    .master_port_select_i(ms), .slot_id_i(slot), .lsp_select_i(sel),
    .local_oe_n_i(oe_n), .b_tck_i({2{m_tck}}), .b_tck_o(), .b_tck_oe_o(tck_oe),
    .b_tms_i(ms ? {m_tms, 1'b1} : {1'b1, m_tms}), .b_tms_o(), .b_tms_oe_o(),
    .b_trst_n_i(ms ? {m_trst_n, 1'b1} : {1'b1, m_trst_n}), .b_trst_n_o(),
    .b_trst_n_oe_o(), .b_tdi_i(ms ? {m_tdi, 1'b1} : {1'b1, m_tdi}),
    .b_tdo_i(2'b00), .b_tdo_o(tdo), .b_tdo_oe_o(tdo_oe), .b_tristate_notify_o(ntf),
    .b_passthru_in_zero_i(pa0), .b_passthru_in_one_i(pa1),
    .b_passthru_out_zero_o(pt0), .b_passthru_out_one_o(pt1), .b_passthru_oe_o(pt_oe),
    .lsp_tdi_i(ltdo | ~ltdo_oe), .lsp_tdo_o(ltdo), .lsp_tdo_oe_o(ltdo_oe),
    .lsp_tms_o(), .lsp_tms_oe_o(ltms_oe), .lsp_tck_o(), .lsp_tck_oe_o(ltck_oe),
    .lsp_trst_n_o(ltrst), .lsp_trst_n_oe_o(), .lsp_tristate_notify_o(lntf),
    .lsp1_passthru_in_zero_i(la0), .lsp1_passthru_in_one_i(la1),
    .lsp1_passthru_out_zero_o(lp0), .lsp1_passthru_out_one_o(lp1),
    .lsp1_passthru_oe_o(lp_oe));

  // compare a value against its expectation
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc

  // outputs held safe while reset is low
  task automatic t_rst;
    chk("notify", 8'h03, ntf);
    chk("local notify", 8'h07, lntf);
    chk("pt oe", 8'h00, {pt_oe, lp_oe});
    chk("local trst", 8'h00, ltrst);
    $display("test reset done");
  endtask : t_rst

  // instruction scan returns the slot address lsb first
  task automatic t_ir;
    logic [7:0] d;
    sm.idle(6);
    sm.ir_scan(8'h3c, d);
    chk("ir capture", slot, d);
    cyc(2);
    chk("tdo released", 8'h00, tdo_oe);
    $display("test ir scan done");
  endtask : t_ir

  // pass-through both ways, then refused selections
  task automatic t_pt;
    logic v;
    @(posedge clk_i);
    oe_n <= 1'b0;
    sel <= SEL_PORT0;
    for (int i = 0; i < 2; i++) begin
      v = i[0];
      @(posedge clk_i);
      pa0 <= {~v, v};
      pa1 <= {v, ~v};
      cyc(10);
      chk("pt zero local", v, pt0[1]);
      chk("pt one local", {7'h00, ~v}, pt1[1]);
      chk("pt zero master", {7'h00, ~v}, pt0[0]);
      chk("pt one master", v, pt1[0]);
      chk("pt oe", 8'h03, pt_oe);
    end
    sel <= SEL_PORT1;
    la0 <= 1'b0;
    pa0 <= 2'b01;
    cyc(10);
    chk("port1 zero back", 8'h00, pt0[0]);
    chk("port1 one back", 8'h01, pt1[0]);
    chk("port1 zero out", 8'h01, lp0);
    chk("port1 one out", 8'h00, lp1);
    chk("port1 oe", 8'h03, {pt_oe, lp_oe});
    for (int i = 0; i < 3; i++) begin
      sel <= (i == 0) ? 7'h00 : (i == 1) ? 7'h03 : 7'h04;
      cyc(10);
      chk("pt refused", 8'h00, {pt_oe, lp_oe});
    end
    $display("test pass-through done");
  endtask : t_pt

  // local enables follow selection and the enable pin
  task automatic t_oe;
    sel <= SEL_PORT1;
    cyc(10);
    chk("tdo oe", 8'h01, ltdo_oe);
    chk("local notify", 8'h06, lntf);
    chk("tck oe", 8'h3f, ltck_oe);
    chk("set roles", 8'h02, tck_oe);
    oe_n <= 1'b1;
    cyc(10);
    chk("released", 8'h00, {ltdo_oe, lp_oe});
    chk("released ctl", 8'h00, ltck_oe | ltms_oe);
    chk("local notify off", 8'h07, lntf);
    $display("test local enable done");
  endtask : t_oe

  // test reset drops the local resets without a clock
  task automatic t_trst;
    oe_n <= 1'b0;
    cyc(10);
    chk("trst idle", 8'h3f, ltrst);
    sm.set_trst(1'b0);
    cyc(2);
    chk("trst low", 8'h00, ltrst);
    chk("notify reset", 8'h03, ntf);
    sm.set_trst(1'b1);
    cyc(10);
    chk("trst back", 8'h3f, ltrst);
    $display("test trst done");
  endtask : t_trst

  // strap picks set one, set zero becomes local port 0
  task automatic t_ms;
    rst_n <= 1'b0;
    ms <= 1'b1;
    sel <= 7'h00;
    slot <= 8'h5a;
    cyc(6);
    rst_n <= 1'b1;
    cyc(4);
    t_ir;
    cyc(10);
    chk("set roles", 8'h01, tck_oe);
    $display("test master set done");
  endtask : t_ms

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  // main sequence; reset held 6 cycles
  initial begin
    rst_n <= 1'b0;
    cyc(3);
    t_rst;
    cyc(3);
    rst_n <= 1'b1;
    cyc(4);
    t_ir;
    t_pt;
    t_oe;
    t_trst;
    t_ms;
    give_verdict;
  end

  // hang guard
  initial begin
    #200000;
    err_count++;
    give_verdict;
  end
endmodule : jpf_fanout_tb_top

`default_nettype wire
